// ---- core/ecoc_channel.v ----
// event capture channel with two-stage buffer, overrun handling, ahb-lite registers
//
// Summary of operation
// - overwrite bit set: new capture on overrun replaces the buffered value.
// - overwrite clear and both stages full: further edges ignored until time read.
// - discarded capture sets the overrun pending flag.
// - reading the time register moves buffer into it and frees the buffer.
// - the buffer-to-time transfer sets capture pending; with the capture interrupt enabled it raises the interrupt.
// - overrun with overrun interrupt enabled raises the interrupt request.
// - read coinciding with edge validation must not leave both stages full unflagged.
`timescale 1ns/1ps
`include "ecoc_map.vh"
module ecoc_channel (
  input wire CLK,
  input wire NRST,
  input wire CAP_IN,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output wire [31:0] HRDATA,
  output wire HREADYOUT,
  output wire HRESP,
  output wire IRQ
);
  reg [`ECOC_CTRL_W-1:0] ctrl_q;
  reg [`ECOC_TW-1:0] timer_q;
  reg [`ECOC_TW-1:0] buf_q;
  reg buf_full_q;
  reg [`ECOC_TW-1:0] time_q;
  reg time_full_q;
  reg [`ECOC_PEND_W-1:0] pend_q;
  reg [`ECOC_PEND_W-1:0] mask_q;
  reg in_q;
  reg ph_wr_q;
  reg ph_rd_q;
  reg [7:0] ph_addr_q;
  reg [31:0] rdata_q;

  function hit;
    input [7:0] a;
    input [3:0] ofs;
    begin
      hit = (a == {4'h0, ofs});
    end
  endfunction

  // address phase capture; every access completes with no wait state
  wire take = HSEL & HREADY & (HTRANS == `ECOC_HTRANS_NONSEQ);
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ph_wr_q <= 1'b0;
      ph_rd_q <= 1'b0;
      ph_addr_q <= 8'h00;
    end else begin
      ph_wr_q <= take & HWRITE;
      ph_rd_q <= take & ~HWRITE;
      ph_addr_q <= HADDR[7:0];
    end
  end

  // read of the time register is acted on at its address phase so data and move align
  wire time_rd = take & ~HWRITE & hit(HADDR[7:0], `ECOC_OFS_TIME);
  wire pend_rd = take & ~HWRITE & hit(HADDR[7:0], `ECOC_OFS_PEND);

  // edge validation on a synchronous input
  wire rise = CAP_IN & ~in_q;
  wire fall = ~CAP_IN & in_q;
  wire edge_ok = ctrl_q[`ECOC_BIT_EN] &
    ((rise & ctrl_q[`ECOC_BIT_RISE]) | (fall & ctrl_q[`ECOC_BIT_FALL]));

  // time stage is free after this cycle if empty or being read
  wire time_free = ~time_full_q | time_rd;
  wire both_full = buf_full_q & time_full_q & ~time_rd;
  wire discard = edge_ok & both_full & ~ctrl_q[`ECOC_BIT_OVW];
  wire overwrite = edge_ok & both_full & ctrl_q[`ECOC_BIT_OVW];
  wire overrun = discard | overwrite;
  reg move;
  reg [`ECOC_TW-1:0] move_val;
  always @* begin
    move = 1'b0;
    move_val = buf_q;
    if (time_free & buf_full_q) begin
      move = 1'b1;
    end else if (time_free & edge_ok) begin
      // buffer empty: a fresh edge goes through to time directly
      move = 1'b1;
      move_val = timer_q;
    end
  end

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      in_q <= 1'b0;
      timer_q <= `ECOC_TIME_RST;
      buf_q <= `ECOC_TIME_RST;
      buf_full_q <= 1'b0;
      time_q <= `ECOC_TIME_RST;
      time_full_q <= 1'b0;
    end else begin
      in_q <= CAP_IN;
      // one writer of the timer here; no channel reset source exists
      if (ph_wr_q & (ph_addr_q == `ECOC_TIMER_OFS))
        timer_q <= HWDATA[`ECOC_TW-1:0];
      else
        timer_q <= timer_q + 1'b1;
      if (move) begin
        time_q <= move_val;
        time_full_q <= 1'b1;
      end else if (time_rd) begin
        time_full_q <= 1'b0;
      end
      // buffer takes the edge unless it went straight through or is discarded
      if (edge_ok & (buf_full_q | ~time_free)) begin
        if (~both_full | overwrite) begin
          buf_q <= timer_q;
          buf_full_q <= 1'b1;
        end
      end else if (move & buf_full_q) begin
        buf_full_q <= 1'b0;
      end
    end
  end

  // pending flags: hardware set wins over read-clear
  wire [`ECOC_PEND_W-1:0] pend_set;
  assign pend_set[`ECOC_PEND_CAP] = move;
  assign pend_set[`ECOC_PEND_OVR] = overrun;
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pend_q <= {`ECOC_PEND_W{1'b0}};
      ctrl_q <= `ECOC_CTRL_RST;
      mask_q <= {`ECOC_PEND_W{1'b0}};
    end else begin
      pend_q <= (pend_rd ? {`ECOC_PEND_W{1'b0}} : pend_q) | pend_set;
      if (ph_wr_q & hit(ph_addr_q, `ECOC_OFS_CTRL))
        ctrl_q <= HWDATA[`ECOC_CTRL_W-1:0];
      if (ph_wr_q & hit(ph_addr_q, `ECOC_OFS_MASK))
        mask_q <= HWDATA[`ECOC_PEND_W-1:0];
    end
  end

  // read data registered from address phase
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rdata_q <= 32'h00000000;
    end else if (take & ~HWRITE) begin
      case (1'b1)
        hit(HADDR[7:0], `ECOC_OFS_CTRL): rdata_q <= {28'h0000000, ctrl_q};
        hit(HADDR[7:0], `ECOC_OFS_TIME): rdata_q <= {16'h0000, (time_full_q ? time_q : buf_q)};
        hit(HADDR[7:0], `ECOC_OFS_PEND): rdata_q <= {30'h00000000, pend_q};
        hit(HADDR[7:0], `ECOC_OFS_MASK): rdata_q <= {30'h00000000, mask_q};
        (HADDR[7:0] == `ECOC_TIMER_OFS): rdata_q <= {16'h0000, timer_q};
        default: rdata_q <= 32'h00000000;
      endcase
    end
  end

  assign HRDATA = rdata_q;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign IRQ = |(pend_q & mask_q);
endmodule

// ---- shared/ecoc_map.vh ----
// register map and field constants for the event capture overrun channel
`ifndef ECOC_MAP_VH
`define ECOC_MAP_VH
`define ECOC_OFS_CTRL 4'h0
`define ECOC_OFS_TIME 4'h4
`define ECOC_OFS_PEND 4'h8
`define ECOC_OFS_MASK 4'hc
`define ECOC_OFS_TIMER 4'h0
`define ECOC_TIMER_OFS 8'h10
`define ECOC_BIT_OVW 0
`define ECOC_BIT_EN 1
`define ECOC_BIT_RISE 2
`define ECOC_BIT_FALL 3
`define ECOC_CTRL_RST 4'h0
`define ECOC_CTRL_W 4
`define ECOC_PEND_CAP 0
`define ECOC_PEND_OVR 1
`define ECOC_PEND_W 2
`define ECOC_TW 16
`define ECOC_TIME_RST 16'h0000
`define ECOC_HTRANS_NONSEQ 2'h2
`define ECOC_ADDR_LSB 2
`endif

// ---- testbench/ecoc_channel_chk.sv ----
// port assertions for the capture channel
`timescale 1ns/1ps
module ecoc_chk (
  input wire CLK,
  input wire NRST,
  input wire CAP_IN,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire HREADY,
  input wire [31:0] HRDATA,
  input wire HREADYOUT,
  input wire HRESP,
  input wire IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  wire tk = HSEL && HREADY && HTRANS == 2'h2;
  wire rd = tk && !HWRITE;
  reg cap_q;
  reg [3:0] act_q;
  // irq may only move shortly after a pin edge or a bus access
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cap_q <= 1'b0;
      act_q <= 4'h0;
    end else begin
      cap_q <= CAP_IN;
      act_q <= {act_q[2:0], tk || CAP_IN != cap_q};
    end
  end
  zero_wait_a: assert property (HREADYOUT) else $error("wait state");
  okay_resp_a: assert property (!HRESP) else $error("bad response");
  irq_cause_a: assert property ($rose(IRQ) |-> act_q != 4'h0) else $error("irq rose alone");
  irq_drop_a: assert property ($fell(IRQ) |-> act_q != 4'h0) else $error("irq fell alone");
  irq_quiet_a: assert property (act_q == 4'h0 |-> $stable(IRQ)) else $error("irq moved idle");
  rdata_hold_a: assert property (!$past(rd) |-> $stable(HRDATA)) else $error("rdata moved");
  unmapped_a: assert property (rd && HADDR[7:0] == 8'h14 |=> HRDATA == 32'h0) else $error("hole");
  ctrl_read_a: assert property (rd && HADDR[7:0] == 8'h00 |=> HRDATA[31:4] == 28'h0) else $error("ctl");
endmodule
bind ecoc_channel ecoc_chk u_chk (.CLK(CLK), .NRST(NRST), .CAP_IN(CAP_IN), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .IRQ(IRQ));

// ---- testbench/ecoc_pin_model.sv ----
// capture pin source that toggles the line on request
`timescale 1ns/1ps
module ecoc_pin_model (
  input wire clk,
  input wire trig,
  output reg pin
);
  initial pin = 1'b0;
  // each toggle is a rise or a fall, both enabled by the bench
  always @(posedge clk) begin
    if (trig) begin
      pin <= ~pin;
    end
  end
endmodule

// ---- testbench/test_event_capture_overrun_channel.sv ----
// bus-driven tests of the capture channel
`timescale 1ns/1ps
module test_event_capture_overrun_channel;
  reg clk = 0, nrst = 0, hsel = 0, hwrite = 0, trig = 0;
  reg [1:0] htrans = 2'h0;
  reg [31:0] haddr = 0, hwdata = 0, t1, t2, p;
  wire [31:0] hrdata;
  wire hrdy, hresp, irq, cap;
  integer error_cnt = 0, checked = 0, ovw;
  initial forever #10 clk = ~clk;
  ecoc_pin_model PIN (.clk(clk), .trig(trig), .pin(cap));
  ecoc_channel DUT (.CLK(clk), .NRST(nrst), .CAP_IN(cap), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy),
    .HRESP(hresp), .IRQ(irq));
  task xfer(input [7:0] a, input w, input [31:0] d, output [31:0] q);
    hsel <= 1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hsel <= 0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      error_cnt = error_cnt + 1;
    end
  endtask
  task give_verdict;
    if (error_cnt == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge clk);
    error_cnt = error_cnt + 1;
    give_verdict;
  end
  initial begin
    for (ovw = 0; ovw < 2; ovw = ovw + 1) begin
      nrst <= 0;
      repeat (10) @(posedge clk);
      nrst <= 1;
      @(posedge clk);
      xfer(8'h0c, 1, 32'h3, p);
      xfer(8'h00, 1, 32'he | ovw, p);
      xfer(8'h10, 1, 32'h1234, p);
      xfer(8'h10, 0, 0, t1);
      chk(t1, 32'h1234);
      xfer(8'h00, 0, 0, p);
      chk(p, 32'he | ovw);
      xfer(8'h14, 0, 0, p);
      chk(p, 0);
      // three edges 20 cycles apart: first to time, second to buffer, third overruns
      repeat (3) begin
        trig <= 1;
        @(posedge clk) trig <= 0;
        repeat (19) @(posedge clk);
      end
      chk(irq, 1);
      xfer(8'h04, 0, 0, t1);
      xfer(8'h04, 0, 0, t2);
      chk((t2 - t1) & 32'hffff, ovw ? 32'd40 : 32'd20);
      xfer(8'h08, 0, 0, p);
      chk(p & 32'h3, 32'h3);
      xfer(8'h08, 0, 0, p);
      chk(p, 0);
      @(posedge clk);
      chk(irq, 0);
      // fill both stages, then land a time read on the edge that gets validated
      repeat (2) begin
        trig <= 1;
        @(posedge clk) trig <= 0;
        repeat (4) @(posedge clk);
      end
      xfer(8'h08, 0, 0, p);
      chk(p & 32'h1, 32'h1);
      trig <= 1;
      @(posedge clk) trig <= 0;
      xfer(8'h04, 0, 0, t1);
      xfer(8'h08, 0, 0, p);
      chk(p & 32'h1, 32'h1);
    end
    give_verdict;
  end
endmodule
